// ==== hdl/acq_pkg.sv ====
// Constants, types and helpers shared by the acquisition trigger sequencer
// How it works
// - Idle never samples; settings applied at initiate
// - Reset puts the engine in Idle
// - Initiate moves Idle to wait-for-start
// - Start source none: leave at once, pulse
// - Selected start trigger: leave next cycle, pulse
// - Pre-reference sampling entered from start or advance
// - Leave pre-sampling when count, converter, holdoff ready
// - First pass ignores the holdoff condition
// - Pretrigger sample count is configurable
// - Arm wait samples; none leaves next edge
// - Reference wait obeys selected source, default none
// - Post-reference entry starts the holdoff counter
// - Leave post-sampling when post count completes
// - Record complete waits for store, pulses end-of-record
// - More records: advance wait, none leaves next edge
// - All records done: Done, pulse end-of-acquisition
// - Fetch command returns Done to Idle
// - Downconvert samples to I/Q words in memory
package acq_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int          ADDR_W        = 6;
  localparam logic [5:0]  REG_CTRL      = 6'h00;
  localparam logic [5:0]  REG_SRC       = 6'h04;
  localparam logic [5:0]  REG_PRETRIG   = 6'h08;
  localparam logic [5:0]  REG_POSTTRIG  = 6'h0C;
  localparam logic [5:0]  REG_HOLDOFF   = 6'h10;
  localparam logic [5:0]  REG_NUMREC    = 6'h14;
  localparam logic [5:0]  REG_STATUS    = 6'h18;
  localparam logic [5:0]  REG_MEM_ADDR  = 6'h1C;
  localparam logic [5:0]  REG_MEM_DATA  = 6'h20;

  // Control register bit positions (write-one pulses)
  localparam int CTRL_INIT      = 0;
  localparam int CTRL_FETCH     = 1;
  localparam int CTRL_SW_START  = 2;
  localparam int CTRL_SW_ARM    = 3;
  localparam int CTRL_SW_REF    = 4;
  localparam int CTRL_SW_ADV    = 5;

  // Source field positions inside the source register
  localparam int SRC_START_LSB  = 0;
  localparam int SRC_ARM_LSB    = 2;
  localparam int SRC_REF_LSB    = 4;
  localparam int SRC_ADV_LSB    = 6;

  // Reset values
  localparam logic [15:0] PRETRIG_RST   = 16'h0010;
  localparam logic [15:0] POSTTRIG_RST  = 16'h0010;
  localparam logic [15:0] HOLDOFF_RST   = 16'h0000;
  localparam logic [15:0] NUMREC_RST    = 16'h0001;

  // Record memory
  localparam int MEM_AW    = 8;
  localparam int MEM_DEPTH = 256;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_SW   = 2'b01,
    SRC_HW   = 2'b10
  } trig_src_t;

  typedef enum logic [8:0] {
    ST_IDLE       = 9'b0_0000_0001,
    ST_WAIT_START = 9'b0_0000_0010,
    ST_MIN_PRE    = 9'b0_0000_0100,
    ST_WAIT_ARM   = 9'b0_0000_1000,
    ST_WAIT_REF   = 9'b0_0001_0000,
    ST_POST_REF   = 9'b0_0010_0000,
    ST_REC_DONE   = 9'b0_0100_0000,
    ST_WAIT_ADV   = 9'b0_1000_0000,
    ST_DONE       = 9'b1_0000_0000
  } acq_state_t;

  typedef struct packed {
    trig_src_t   adv_src;
    trig_src_t   ref_src;
    trig_src_t   arm_src;
    trig_src_t   start_src;
    logic [15:0] pretrig;
    logic [15:0] posttrig;
    logic [15:0] holdoff;
    logic [15:0] numrec;
  } acq_cfg_t;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } iq_t;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Trigger recognised for the selected source
  function automatic logic trig_hit(input trig_src_t src, input logic sw, input logic hw);
    trig_hit = (src == SRC_NONE) || (src == SRC_SW && sw) || (src == SRC_HW && hw);
  endfunction : trig_hit

  // Byte-enable merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : be_merge

  // Quarter-rate mixer: multiply by cos and -sin at one quarter of the sample rate
  function automatic iq_t ddc_mix(input logic [15:0] s, input logic [1:0] ph);
    logic [15:0] neg;
    neg = 16'(~s + 16'h0001);
    unique case (ph)
      2'd0: ddc_mix = '{i: s,     q: 16'h0000};
      2'd1: ddc_mix = '{i: 16'h0000, q: neg};
      2'd2: ddc_mix = '{i: neg,   q: 16'h0000};
      2'd3: ddc_mix = '{i: 16'h0000, q: s};
    endcase
  endfunction : ddc_mix

endpackage : acq_pkg

// ==== hdl/acq_trigger_sequencer.sv ====
// Acquisition trigger sequencer with Avalon-MM register slave and record memory
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module acq_trigger_sequencer
  import acq_pkg::*;
(
  input  wire logic                I_CORE_CLK,
  input  wire logic                I_NRST,
  input  wire logic [ADDR_W-1:0]   I_AVS_ADDRESS,
  input  wire logic                I_AVS_READ,
  input  wire logic                I_AVS_WRITE,
  input  wire logic [31:0]         I_AVS_WRITEDATA,
  input  wire logic [3:0]          I_AVS_BYTEENABLE,
  output var  logic [31:0]         O_AVS_READDATA,
  output var  logic                O_AVS_WAITREQUEST,
  input  wire logic                I_HW_TRIG,
  input  wire logic                I_TDC_READY,
  input  wire logic [15:0]         I_SAMPLE,
  input  wire logic                I_SAMPLE_VALID,
  output var  logic                O_START_TRIG,
  output var  logic                O_END_OF_RECORD,
  output var  logic                O_END_OF_ACQ,
  output var  logic [8:0]          O_ACQ_STATE
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  acq_state_t        state;
  acq_cfg_t          shadow;          // Software view of the settings
  acq_cfg_t          active;          // Settings the engine runs with
  logic [31:0]       src_word;
  logic [31:0]       src_merged;
  logic              bus_take;
  logic              wr_hit;
  logic [5:0]        ctrl_pulse;
  logic              hw_meta;
  logic              hw_sync;
  logic              hw_prev;
  logic              hw_edge;
  logic [15:0]       pre_cnt;
  logic [15:0]       post_cnt;
  logic [15:0]       holdoff_cnt;
  logic [15:0]       rec_cnt;
  logic              first_pass;
  logic              sampling;
  logic [1:0]        phase;
  logic              wr_pend;
  iq_t               wr_data;
  logic [MEM_AW-1:0] wr_addr;
  logic [MEM_AW-1:0] wr_ptr;
  logic [MEM_AW-1:0] rd_addr;
  logic [31:0]       mem [MEM_DEPTH];
  logic              start_go;
  logic              arm_go;
  logic              ref_go;
  logic              adv_go;
  logic              pre_ready;
  logic              post_ready;
  logic              last_rec;
  acq_state_t        next_state;

  // ------------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------------
  // Request is accepted in the cycle where waitrequest is low
  assign bus_take = (I_AVS_READ || I_AVS_WRITE) && !O_AVS_WAITREQUEST;
  assign wr_hit   = I_AVS_WRITE && !O_AVS_WAITREQUEST;
  assign src_word = {24'h00_0000, shadow.adv_src, shadow.ref_src,
                     shadow.arm_src, shadow.start_src};
  // Source word after the byte lanes of a write are merged in
  assign src_merged = be_merge(src_word, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);

  // Waitrequest drops for exactly one cycle after a request is seen
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_AVS_WAITREQUEST <= 1'b1;
    end else if ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST) begin
      O_AVS_WAITREQUEST <= 1'b0;
    end else begin
      O_AVS_WAITREQUEST <= 1'b1;
    end
  end

  // Read data registered while waitrequest is still high; unmapped reads give zero
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (I_AVS_READ && O_AVS_WAITREQUEST) begin
      unique case (I_AVS_ADDRESS)
        REG_SRC:      O_AVS_READDATA <= src_word;
        REG_PRETRIG:  O_AVS_READDATA <= {16'h0000, shadow.pretrig};
        REG_POSTTRIG: O_AVS_READDATA <= {16'h0000, shadow.posttrig};
        REG_HOLDOFF:  O_AVS_READDATA <= {16'h0000, shadow.holdoff};
        REG_NUMREC:   O_AVS_READDATA <= {16'h0000, shadow.numrec};
        REG_STATUS:   O_AVS_READDATA <= {rec_cnt, 7'h00, state};
        REG_MEM_ADDR: O_AVS_READDATA <= {24'h00_0000, rd_addr};
        REG_MEM_DATA: O_AVS_READDATA <= mem[rd_addr];
        default:      O_AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Settings stay writable at any time; they only reach the engine on initiate
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      shadow  <= '{SRC_NONE, SRC_NONE, SRC_NONE, SRC_NONE,
                   PRETRIG_RST, POSTTRIG_RST, HOLDOFF_RST, NUMREC_RST};
      rd_addr <= '0;
    end else if (wr_hit) begin
      unique case (I_AVS_ADDRESS)
        REG_SRC: begin
          // Each field is cast on its own; an enum takes no raw vector
          shadow.start_src <= trig_src_t'(src_merged[SRC_START_LSB +: 2]);
          shadow.arm_src   <= trig_src_t'(src_merged[SRC_ARM_LSB +: 2]);
          shadow.ref_src   <= trig_src_t'(src_merged[SRC_REF_LSB +: 2]);
          shadow.adv_src   <= trig_src_t'(src_merged[SRC_ADV_LSB +: 2]);
        end
        REG_PRETRIG: begin
          shadow.pretrig <= 16'(be_merge({16'h0000, shadow.pretrig},
                                         I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        end
        REG_POSTTRIG: begin
          shadow.posttrig <= 16'(be_merge({16'h0000, shadow.posttrig},
                                          I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        end
        REG_HOLDOFF: begin
          shadow.holdoff <= 16'(be_merge({16'h0000, shadow.holdoff},
                                         I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        end
        REG_NUMREC: begin
          shadow.numrec <= 16'(be_merge({16'h0000, shadow.numrec},
                                        I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        end
        REG_MEM_ADDR: begin
          rd_addr <= MEM_AW'(be_merge({24'h00_0000, rd_addr},
                                      I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        end
        default: ;
      endcase
    end
  end

  // Control write produces one-cycle command and software trigger pulses
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      ctrl_pulse <= 6'h00;
    end else if (wr_hit && I_AVS_ADDRESS == REG_CTRL && I_AVS_BYTEENABLE[0]) begin
      ctrl_pulse <= I_AVS_WRITEDATA[5:0];
    end else begin
      ctrl_pulse <= 6'h00;
    end
  end

  // ------------------------------------------------------------------
  // Hardware trigger input
  // ------------------------------------------------------------------
  // Two-stage synchroniser then rising-edge detect on the second stage
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      hw_meta <= 1'b0;
      hw_sync <= 1'b0;
      hw_prev <= 1'b0;
    end else begin
      hw_meta <= I_HW_TRIG;
      hw_sync <= hw_meta;
      hw_prev <= hw_sync;
    end
  end
  assign hw_edge = hw_sync && !hw_prev;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  assign start_go   = trig_hit(active.start_src, ctrl_pulse[CTRL_SW_START], hw_edge);
  assign arm_go     = trig_hit(active.arm_src, ctrl_pulse[CTRL_SW_ARM], hw_edge);
  assign ref_go     = trig_hit(active.ref_src, ctrl_pulse[CTRL_SW_REF], hw_edge);
  assign adv_go     = trig_hit(active.adv_src, ctrl_pulse[CTRL_SW_ADV], hw_edge);
  assign pre_ready  = (pre_cnt >= active.pretrig) && I_TDC_READY
                      && (first_pass || holdoff_cnt == 16'h0000);
  assign post_ready = post_cnt >= active.posttrig;
  assign last_rec   = 16'(rec_cnt + 16'h0001) >= active.numrec;

  // Next-state decode
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:       if (ctrl_pulse[CTRL_INIT]) next_state = ST_WAIT_START;
      ST_WAIT_START: if (start_go) next_state = ST_MIN_PRE;
      ST_MIN_PRE:    if (pre_ready) next_state = ST_WAIT_ARM;
      ST_WAIT_ARM:   if (arm_go) next_state = ST_WAIT_REF;
      ST_WAIT_REF:   if (ref_go) next_state = ST_POST_REF;
      ST_POST_REF:   if (post_ready) next_state = ST_REC_DONE;
      ST_REC_DONE: begin
        if (!wr_pend) next_state = last_rec ? ST_DONE : ST_WAIT_ADV;
      end
      ST_WAIT_ADV:   if (adv_go) next_state = ST_MIN_PRE;
      ST_DONE:       if (ctrl_pulse[CTRL_FETCH]) next_state = ST_IDLE;
      default:       next_state = ST_IDLE;
    endcase
  end

  // State register; reset lands in Idle
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  assign O_ACQ_STATE = state;

  // Settings are copied into the engine only on initiate
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      active <= '{SRC_NONE, SRC_NONE, SRC_NONE, SRC_NONE,
                  PRETRIG_RST, POSTTRIG_RST, HOLDOFF_RST, NUMREC_RST};
    end else if (state == ST_IDLE && ctrl_pulse[CTRL_INIT]) begin
      active <= shadow;
    end
  end

  // Event pulses, each one cycle wide
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_START_TRIG    <= 1'b0;
      O_END_OF_RECORD <= 1'b0;
      O_END_OF_ACQ    <= 1'b0;
    end else begin
      O_START_TRIG    <= state == ST_WAIT_START && start_go;
      O_END_OF_RECORD <= state == ST_REC_DONE && !wr_pend;
      O_END_OF_ACQ    <= state == ST_REC_DONE && !wr_pend && last_rec;
    end
  end

  // Pre, post and record counters
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      pre_cnt  <= 16'h0000;
      post_cnt <= 16'h0000;
      rec_cnt  <= 16'h0000;
    end else begin
      if (state != ST_MIN_PRE) begin
        pre_cnt <= 16'h0000;
      end else if (I_SAMPLE_VALID && pre_cnt != 16'hFFFF) begin
        pre_cnt <= 16'(pre_cnt + 16'h0001);
      end
      if (state != ST_POST_REF) begin
        post_cnt <= 16'h0000;
      end else if (I_SAMPLE_VALID && !post_ready) begin
        post_cnt <= 16'(post_cnt + 16'h0001);
      end
      if (state == ST_IDLE && ctrl_pulse[CTRL_INIT]) begin
        rec_cnt <= 16'h0000;
      end else if (state == ST_REC_DONE && !wr_pend) begin
        rec_cnt <= 16'(rec_cnt + 16'h0001);
      end
    end
  end

  // Holdoff counter loads as post-reference sampling begins
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      holdoff_cnt <= 16'h0000;
      first_pass  <= 1'b0;
    end else begin
      if (state == ST_WAIT_REF && ref_go) begin
        holdoff_cnt <= active.holdoff;
      end else if (holdoff_cnt != 16'h0000) begin
        holdoff_cnt <= 16'(holdoff_cnt - 16'h0001);
      end
      if (state == ST_IDLE && ctrl_pulse[CTRL_INIT]) begin
        first_pass <= 1'b1;
      end else if (state == ST_MIN_PRE && pre_ready) begin
        first_pass <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Downconversion and record memory
  // ------------------------------------------------------------------
  // Sampling only in the four sampling states, never in Idle
  assign sampling = (state == ST_MIN_PRE) || (state == ST_WAIT_ARM)
                    || (state == ST_WAIT_REF) || (state == ST_POST_REF && !post_ready);

  // One-stage write pipe; record complete waits for it to drain
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      phase   <= 2'd0;
      wr_pend <= 1'b0;
      wr_data <= '0;
      wr_addr <= '0;
      wr_ptr  <= '0;
    end else begin
      wr_pend <= sampling && I_SAMPLE_VALID;
      if (state == ST_IDLE && ctrl_pulse[CTRL_INIT]) begin
        phase  <= 2'd0;
        wr_ptr <= '0;
      end else if (sampling && I_SAMPLE_VALID) begin
        phase   <= 2'(phase + 2'd1);
        wr_data <= ddc_mix(I_SAMPLE, phase);
        wr_addr <= wr_ptr;
        wr_ptr  <= MEM_AW'(wr_ptr + 1'b1);                            // Wraps at depth
      end
    end
  end

  // I/Q word store, I in the upper half
  always_ff @(posedge I_CORE_CLK) begin
    if (wr_pend) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_req_seen;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
  endsequence
  sequence s_one_answer;
    !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
  endsequence

  a_idle_after_reset: assert property (@(posedge I_CORE_CLK) disable iff (1'b0)
    !I_NRST |=> state == ST_IDLE) else $error("engine not idle after reset");
  a_initiate_moves: assert property (
    state == ST_IDLE && ctrl_pulse[CTRL_INIT] |=> state == ST_WAIT_START)
    else $error("initiate did not reach wait for start");
  a_start_none_fast: assert property (
    state == ST_WAIT_START && active.start_src == SRC_NONE
    |=> O_START_TRIG && state == ST_MIN_PRE)
    else $error("start source none did not leave at once");
  a_start_one_cycle: assert property (
    O_START_TRIG |=> !O_START_TRIG) else $error("start trigger wider than one cycle");
  a_holdoff_blocks: assert property (
    state == ST_MIN_PRE && !first_pass && holdoff_cnt != 16'h0000 |=> state != ST_WAIT_ARM)
    else $error("pre-sampling left during holdoff");
  a_eor_on_leave: assert property (
    state == ST_REC_DONE && !wr_pend |=> O_END_OF_RECORD && state != ST_REC_DONE)
    else $error("end of record missing on leaving");
  a_eoa_on_entry: assert property (
    state == ST_DONE && $past(state) != ST_DONE |-> O_END_OF_ACQ)
    else $error("end of acquisition missing on entering done");
  a_done_to_idle: assert property (
    state == ST_DONE && ctrl_pulse[CTRL_FETCH] |=> state == ST_IDLE)
    else $error("fetch did not return to idle");
  a_bus_answer: assert property (
    s_req_seen |=> s_one_answer) else $error("bus answer not a single cycle");

  sequence s_sw_start_seen;
    state == ST_WAIT_START && active.start_src == SRC_SW && ctrl_pulse[CTRL_SW_START];
  endsequence

  a_sw_start_next: assert property (
    s_sw_start_seen |=> O_START_TRIG && state == ST_MIN_PRE)
    else $error("software start trigger not taken on next cycle");
  a_pre_count: assert property (
    state == ST_MIN_PRE && pre_cnt < active.pretrig |=> state == ST_MIN_PRE)
    else $error("pre-sampling left before pretrigger count");
  a_converter_busy: assert property (
    state == ST_MIN_PRE && !I_TDC_READY |=> state == ST_MIN_PRE)
    else $error("pre-sampling left while converter busy");
  a_arm_none_fast: assert property (
    state == ST_WAIT_ARM && active.arm_src == SRC_NONE |=> state == ST_WAIT_REF)
    else $error("arm source none did not leave at once");
  a_holdoff_load: assert property (
    state == ST_WAIT_REF && ref_go |=> state == ST_POST_REF && holdoff_cnt == active.holdoff)
    else $error("holdoff not loaded on post-reference entry");
  a_post_count: assert property (
    state == ST_POST_REF && !post_ready |=> state == ST_POST_REF)
    else $error("post-sampling left before post count");
  a_adv_none_fast: assert property (
    state == ST_WAIT_ADV && active.adv_src == SRC_NONE |=> state == ST_MIN_PRE)
    else $error("advance source none did not leave at once");
  a_idle_no_store: assert property (
    state == ST_IDLE |=> !wr_pend) else $error("sample stored while idle");
  a_eor_one_cycle: assert property (
    O_END_OF_RECORD |=> !O_END_OF_RECORD) else $error("end of record wider than one cycle");
  a_eoa_one_cycle: assert property (
    O_END_OF_ACQ |=> !O_END_OF_ACQ) else $error("end of acquisition wider than one cycle");

endmodule : acq_trigger_sequencer

`default_nettype wire

// ==== verification/acq_far_side.sv ====
// Trigger pin and sample stream in front of the sequencer
`timescale 1ns/10ps
`default_nettype none

module acq_far_side
  import acq_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_fire,
  output var  logic        o_hw_trig,
  output var  logic [15:0] o_sample,
  output var  logic        o_sample_valid,
  output var  logic        o_tdc_ready
);
  logic [1:0] hold;

  // Pin held high three cycles so the two-flop synchroniser sees one edge
  always_ff @(posedge i_clk) begin
    if (!i_nrst) hold <= 2'h0;
    else if (i_fire) hold <= 2'h3;
    else if (hold != 2'h0) hold <= hold - 2'h1;
  end
  assign o_hw_trig = (hold != 2'h0);

  // One sample every cycle; converter drops ready one cycle in sixteen
  always_ff @(posedge i_clk) begin
    o_sample       <= i_nrst ? o_sample + 16'h0101 : 16'h0000;
    o_sample_valid <= i_nrst;
    o_tdc_ready    <= i_nrst && o_sample[3:0] != 4'h7;
  end
endmodule : acq_far_side
`default_nettype wire

// ==== verification/tb_acq_trigger_sequencer.sv ====
// Self-checking bench for the acquisition trigger sequencer
`timescale 1ns/10ps
`default_nettype none

module tb_acq_trigger_sequencer
  import acq_pkg::*;
();
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic        waitreq;
  logic        fire = 1'b0;
  logic        hw_trig;
  logic [15:0] sample;
  logic        svalid;
  logic        tdc_rdy;
  logic        start_trig;
  logic        eor;
  logic        eoa;
  logic [8:0]  state;
  logic [2:0]  prev = 3'h0;
  logic [31:0] seed;
  logic [31:0] q;
  logic [31:0] w0;
  int          mismatches = 0;
  int          checks = 0;
  int          n_start = 0;
  int          n_eor = 0;
  int          n_eoa = 0;

  always #12.5 clk = ~clk;

  acq_trigger_sequencer uut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hf),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_HW_TRIG(hw_trig),
    .I_TDC_READY(tdc_rdy), .I_SAMPLE(sample), .I_SAMPLE_VALID(svalid),
    .O_START_TRIG(start_trig), .O_END_OF_RECORD(eor), .O_END_OF_ACQ(eoa), .O_ACQ_STATE(state));

  acq_far_side far (.i_clk(clk), .i_nrst(nrst), .i_fire(fire), .o_hw_trig(hw_trig),
    .o_sample(sample), .o_sample_valid(svalid), .o_tdc_ready(tdc_rdy));

  // Count event pulses and flag any pulse that lasts two cycles
  always @(posedge clk) begin
    if ((start_trig && prev[0]) || (eor && prev[1]) || (eoa && prev[2])) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t event longer than one cycle", $time);
    end
    prev <= {eoa, eor, start_trig};
    n_start <= n_start + int'(start_trig);
    n_eor <= n_eor + int'(eor);
    n_eoa <= n_eoa + int'(eoa);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Phase-1 word after a phase-0 word; samples step by 16'h0101 each cycle
  function automatic logic [31:0] next_iq(input logic [31:0] w);
    return {16'h0000, 16'(16'h0000 - (w[31:16] + 16'h0101))};
  endfunction : next_iq

  task automatic end_sim;
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) begin
      chk(32'h0000_0000, 32'h0000_0001);
      end_sim();
    end
  endtask : bus

  task automatic wait_st(input acq_state_t st);
    int n;
    n = 0;
    while (state !== st && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(state), 32'(st));
    if (n >= 3000) end_sim();
  endtask : wait_st

  // Hold in a waiting state, refuse stray commands, then give the trigger
  task automatic gate(input acq_state_t st, input logic [1:0] s, input int b);
    if (s != 2'h0) begin
      wait_st(st);
      bus(1'b1, REG_CTRL, 32'h0000_0003);
      repeat (8) @(posedge clk);
      chk(32'(state), 32'(st));
      if (s == 2'h1) bus(1'b1, REG_CTRL, 32'h0000_0001 << b);
      else begin
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
      end
    end
  endtask : gate

  task automatic acq(input logic [7:0] src, input logic [15:0] pre, post, nrec);
    int s0, e0, a0;
    s0 = n_start;
    e0 = n_eor;
    a0 = n_eoa;
    bus(1'b1, REG_SRC, {24'h00_0000, src});
    bus(1'b1, REG_PRETRIG, {16'h0000, pre});
    bus(1'b1, REG_POSTTRIG, {16'h0000, post});
    bus(1'b1, REG_NUMREC, {16'h0000, nrec});
    repeat (8) @(posedge clk);
    chk(32'(state), 32'(ST_IDLE));
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    gate(ST_WAIT_START, src[1:0], CTRL_SW_START);
    for (int r = 0; r < int'(nrec); r++) begin
      if (r > 0) gate(ST_WAIT_ADV, src[7:6], CTRL_SW_ADV);
      gate(ST_WAIT_ARM, src[3:2], CTRL_SW_ARM);
      gate(ST_WAIT_REF, src[5:4], CTRL_SW_REF);
    end
    wait_st(ST_DONE);
    @(posedge clk);
    chk(32'(n_start - s0), 32'h0000_0001);
    chk(32'(n_eor - e0), 32'(nrec));
    chk(32'(n_eoa - a0), 32'h0000_0001);
    bus(1'b1, REG_CTRL, 32'h0000_0002);
    wait_st(ST_IDLE);
  endtask : acq

  initial begin
    seed = 32'h0000_954c;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(32'(state), 32'(ST_IDLE));
    bus(1'b0, REG_SRC, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b0, REG_PRETRIG, 32'h0000_0000);
    chk(q, {16'h0000, PRETRIG_RST});
    bus(1'b0, REG_NUMREC, 32'h0000_0000);
    chk(q, {16'h0000, NUMREC_RST});
    bus(1'b0, 6'h3c, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    acq(8'h00, 16'h0001, 16'h0001, 16'h0001);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    chk(q, {16'h0001, 7'h00, ST_IDLE});
    bus(1'b0, REG_MEM_DATA, 32'h0000_0000);
    w0 = q;
    chk({16'h0000, w0[15:0]}, 32'h0000_0000);
    bus(1'b1, REG_MEM_ADDR, 32'h0000_0001);
    bus(1'b0, REG_MEM_DATA, 32'h0000_0000);
    chk(q, next_iq(w0));
    acq(8'h61, 16'h0002, 16'h0003, 16'h0002);
    acq(8'h96, 16'h0004, 16'h0002, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1'b1, REG_HOLDOFF, {28'h000_0000, seed[3:0]});
      acq(8'h00, 16'(seed[6:4]) + 16'h0001, 16'(seed[9:7]) + 16'h0001,
          16'(seed[11:10]) + 16'h0001);
    end
    // Reset while waiting for a start trigger returns engine and settings
    bus(1'b1, REG_SRC, 32'h0000_0001);
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    wait_st(ST_WAIT_START);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(32'(state), 32'(ST_IDLE));
    bus(1'b0, REG_SRC, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    end_sim();
  end
endmodule : tb_acq_trigger_sequencer
`default_nettype wire
